// File: pkg/wdrc_pkg.sv
/*
 * wdrc_pkg: shared constants and carrier types for the watchdog with
 * reset-cause flags. Assumes a 32-bit APB register bus and a 100 MHz clk_sys.
 */
package wdrc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] WDRC_CTRL_ADDR  = 12'h060;
    localparam logic [11:0] WDRC_CAUSE_ADDR = 12'h064;
    localparam logic [11:0] WDRC_CMD_ADDR   = 12'h068;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_IRQ_FLAG   = 7;
    localparam int CTRL_IRQ_EN     = 6;
    localparam int CTRL_SEL3       = 5;
    localparam int CTRL_CHG_EN     = 4;
    localparam int CTRL_RST_EN     = 3;
    localparam int CTRL_SEL_HI     = 2;

    // ------------------------------------------------------------------
    // reset-cause fields
    // ------------------------------------------------------------------
    localparam int CAUSE_WDOG      = 3;
    localparam int CAUSE_BROWNOUT  = 2;
    localparam int CAUSE_PIN       = 1;
    localparam int CAUSE_POWERON   = 0;

    // command register: bit 0 restarts the counter, bit 1 acks the vector
    localparam int CMD_RESTART     = 0;
    localparam int CMD_VECTOR_ACK  = 1;

    // ------------------------------------------------------------------
    // timing and period selection
    // ------------------------------------------------------------------
    localparam int          CHG_WINDOW_CYCLES = 4;
    localparam logic [3:0]  SEL_MAX_CODE      = 4'h9;
    localparam int          BASE_TIMEOUT_LOG2 = 11;
    localparam int          CNT_WIDTH         = 21;
    localparam logic [3:0]  SEL_RESET_VALUE   = 4'h0;

    typedef enum logic [1:0]
    {
        WDRC_STOPPED   = 2'b00,
        WDRC_IRQ_ONLY  = 2'b01,
        WDRC_RST_ONLY  = 2'b10,
        WDRC_IRQ_RST   = 2'b11
    } wdrc_mode_type;

    typedef struct packed
    {
        logic brownout;
        logic pin;
        logic poweron;
    } wdrc_cause_type;

endpackage

// File: tb/watchdog_with_reset_cause_flags_test.sv
/* watchdog_with_reset_cause_flags_test: directed bench for wdrc_watchdog.
   assumes the apb timing and register map of the package. */
`timescale 1ns/100ps
module watchdog_with_reset_cause_flags_test;
    import wdrc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        lfOscClk = 1'b0;
    logic        alwaysOnOption_n = 1'b1;
    logic [2:0]  evt = 3'h0;
    logic        globalIrqEnable = 1'b0;
    logic        timeoutIrq;
    logic        systemReset;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          n_checks = 0;
    int          ticks = 0;
    int          rstCount = 0;

    wdrc_watchdog dut_u (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .lfOscClk, .alwaysOnOption_n, .brownoutEvent(evt[2]),
        .pinResetEvent(evt[1]), .poweronEvent(evt[0]), .globalIrqEnable, .timeoutIrq,
        .systemReset);

    always #5 clk_sys = ~clk_sys;
    // odd half period keeps the oscillator unrelated to clk_sys
    always #31 lfOscClk = ~lfOscClk;
    always @(posedge lfOscClk) ticks++;
    always @(posedge clk_sys) if (systemReset === 1'b1) rstCount++;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic summarize;
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge: the next call must not drive psel again in this step
        @(posedge clk_sys);
        if (n >= 20)
            chk(32'h1, 32'h0);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic pulse(input logic [2:0] v);
        evt <= v;
        cyc(6);
        evt <= 3'h0;
        cyc(6);
    endtask
    // bounded wait: sel 0 for the interrupt, 1 for the system reset
    task automatic waitEv(input bit sel);
        int n;
        n = 0;
        while ((sel ? systemReset : timeoutIrq) !== 1'b1 && n < 20000)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 20000)
            chk(32'h1, 32'h0);
    endtask
    task automatic tickChk;
        chk({31'h0, ticks >= 2046 && ticks <= 2050}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rdChk(WDRC_CTRL_ADDR, 32'hf7, 32'h0);
        rdChk(WDRC_CAUSE_ADDR, 32'hffffffff, 32'h0);
        xfer(12'h06c, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_cause;
        pulse(3'b110);
        rdChk(WDRC_CAUSE_ADDR, 32'hffffffff, 32'h6);
        xfer(WDRC_CAUSE_ADDR, 1'b1, 32'h0);
        rdChk(WDRC_CAUSE_ADDR, 32'hffffffff, 32'h0);
        pulse(3'b010);
        pulse(3'b001);
        rdChk(WDRC_CAUSE_ADDR, 32'hffffffff, 32'h1);
        xfer(WDRC_CAUSE_ADDR, 1'b1, 32'hfe);
        rdChk(WDRC_CAUSE_ADDR, 32'hffffffff, 32'h0);
    endtask
    task automatic t_window;
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h08);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h01);
        rdChk(WDRC_CTRL_ADDR, 32'hff, 32'h08);
        xfer(WDRC_CMD_ADDR, 1'b1, 32'h1);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h18);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h01);
        rdChk(WDRC_CTRL_ADDR, 32'hff, 32'h01);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h19);
        cyc(6);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h00);
        rdChk(WDRC_CTRL_ADDR, 32'hff, 32'h09);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h19);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h00);
        rdChk(WDRC_CTRL_ADDR, 32'hff, 32'h00);
    endtask
    task automatic t_irq;
        globalIrqEnable <= 1'b1;
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h40);
        // half a period in, so only a working restart gives a full period
        cyc(6000);
        xfer(WDRC_CMD_ADDR, 1'b1, 32'h1);
        ticks = 0;
        waitEv(1'b0);
        tickChk();
        rdChk(WDRC_CTRL_ADDR, 32'hff, 32'hc0);
        globalIrqEnable <= 1'b0;
        cyc(3);
        chk({31'h0, timeoutIrq}, 32'h0);
        globalIrqEnable <= 1'b1;
        cyc(3);
        chk({31'h0, timeoutIrq}, 32'h1);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'hc0);
        rdChk(WDRC_CTRL_ADDR, 32'hff, 32'h40);
        chk(rstCount, 32'h0);
    endtask
    task automatic t_comb;
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h48);
        xfer(WDRC_CMD_ADDR, 1'b1, 32'h1);
        waitEv(1'b0);
        rdChk(WDRC_CTRL_ADDR, 32'hff, 32'hc8);
        chk(rstCount, 32'h0);
        xfer(WDRC_CMD_ADDR, 1'b1, 32'h2);
        rdChk(WDRC_CTRL_ADDR, 32'hff, 32'h08);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h48);
        waitEv(1'b0);
        ticks = 0;
        waitEv(1'b1);
        tickChk();
        rdChk(WDRC_CAUSE_ADDR, 32'hffffffff, 32'h8);
        chk(rstCount, 32'h1);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h18);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h00);
        rdChk(WDRC_CTRL_ADDR, 32'h08, 32'h08);
        xfer(WDRC_CAUSE_ADDR, 1'b1, 32'h0);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h18);
        xfer(WDRC_CTRL_ADDR, 1'b1, 32'h00);
        rdChk(WDRC_CTRL_ADDR, 32'h08, 32'h00);
    endtask
    task automatic t_always;
        alwaysOnOption_n <= 1'b0;
        cyc(6);
        rdChk(WDRC_CTRL_ADDR, 32'h08, 32'h08);
        alwaysOnOption_n <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        cyc(16);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_cause();
        t_window();
        t_irq();
        t_comb();
        t_always();
        summarize();
    end
    // four time-outs of about 13k cycles each fit well inside this
    initial
    begin
        #900000;
        mismatches++;
        summarize();
    end
endmodule

// File: tb/wdrc_watchdog_sva.sv
/* wdrc_watchdog_sva: port checker for wdrc_watchdog.
   assumes only the top ports; bound below. */
`timescale 1ns/100ps
module wdrc_watchdog_sva
    import wdrc_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // side signals
    input wire logic        alwaysOnOption_n,
    input wire logic        globalIrqEnable,
    input wire logic        timeoutIrq,
    input wire logic        systemReset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic rdDone;
    logic mapped;
    assign rdDone = psel && pready && !pwrite;
    assign mapped = paddr inside {WDRC_CTRL_ADDR, WDRC_CAUSE_ADDR, WDRC_CMD_ADDR};
    property p_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after access");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_slverr;
        pready |-> (pslverr == !mapped);
    endproperty
    a_slverr: assert property (p_slverr) else $error("error response wrong");
    property p_idle_data;
        !pready |-> prdata == 32'h0;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("read data not idle");
    property p_cause_upper;
        rdDone && paddr == WDRC_CAUSE_ADDR |-> prdata[31:4] == 28'h0;
    endproperty
    a_cause_upper: assert property (p_cause_upper) else $error("cause upper bits");
    property p_rst_pulse;
        systemReset |=> !systemReset;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    property p_irq_gate;
        !globalIrqEnable |=> !timeoutIrq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
    property p_always_on;
        (!alwaysOnOption_n)[*6] ##0 (rdDone && paddr == WDRC_CTRL_ADDR) |-> prdata[3];
    endproperty
    a_always_on: assert property (p_always_on) else $error("reset mode not forced");
    property p_irq_src;
        $rose(timeoutIrq) |-> $past(globalIrqEnable);
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq rose while disabled");
endmodule

bind wdrc_watchdog wdrc_watchdog_sva chk_u (.clk_sys, .arst_n, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .alwaysOnOption_n, .globalIrqEnable, .timeoutIrq,
    .systemReset);

// File: verilog/wdrc_watchdog.sv
/*
 * wdrc_watchdog: watchdog timer with reset-cause status, APB slave.
 * Assumes the low-frequency oscillator, the always-on option and the reset
 * cause inputs arrive asynchronously; all are synchronised into clk_sys.
 */
// What this block does
// - cause register bits 7..4 read zero
// - watchdog cause set by wdog reset
// - brownout cause set by brownout reset
// - pin cause set by external reset
// - poweron cause cleared only by software
// - irq flag set on timeout, cleared
// - interrupt needs global and local enable
// - combined mode vector clears enable, flag
// - unserviced second timeout forces system reset
// - enable bits select the four modes
// - always-on option forces reset mode
// - guarded changes need change window open
// - change window closes after four cycles
// - reset enable forced while wdog cause
// - period select is bit5 and 2..0
// - codes 0..9 double 2048 cycles upward
// - counter advances on oscillator ticks
// - restart command clears the counter
// - system reset pulse lasts one cycle
`timescale 1ns/100ps

module wdrc_watchdog
    import wdrc_pkg::*;
#(
    parameter int CHG_CYCLES = CHG_WINDOW_CYCLES
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // asynchronous inputs
    input  wire logic        lfOscClk,
    input  wire logic        alwaysOnOption_n,
    input  wire logic        brownoutEvent,
    input  wire logic        pinResetEvent,
    input  wire logic        poweronEvent,
    // processor side
    input  wire logic        globalIrqEnable,
    output logic             timeoutIrq,
    output logic             systemReset
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (CHG_CYCLES < 1 || CHG_CYCLES > 15)
    begin : gBadChg
        $error("CHG_CYCLES out of range");
    end

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] syncA_reg;
    logic [NSYNC-1:0] syncB_reg;
    logic [NSYNC-1:0] prev_reg;
    logic [NSYNC-1:0] asyncIn;

    assign asyncIn = {poweronEvent, pinResetEvent, brownoutEvent, alwaysOnOption_n, lfOscClk};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : gSync
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    syncA_reg[gi] <= 1'b0;
                    syncB_reg[gi] <= 1'b0;
                    prev_reg[gi]  <= 1'b0;
                end
                else
                begin
                    syncA_reg[gi] <= asyncIn[gi];
                    syncB_reg[gi] <= syncA_reg[gi];
                    prev_reg[gi]  <= syncB_reg[gi];
                end
            end
        end
    endgenerate

    logic oscS;
    logic alwaysOn;
    logic brownS;
    logic pinS;
    logic ponS;
    assign oscS     = syncB_reg[0];
    // option programmed means value 0; low twice so a glitch cannot force it
    assign alwaysOn = ~(syncB_reg[1] | prev_reg[1]);
    assign brownS   = syncB_reg[2];
    assign pinS     = syncB_reg[3];
    assign ponS     = syncB_reg[4];

    logic oscTick;
    logic brownRise;
    logic pinRise;
    logic ponRise;
    assign oscTick   = oscS & ~prev_reg[0];
    assign brownRise = brownS & ~prev_reg[2];
    assign pinRise   = pinS & ~prev_reg[3];
    assign ponRise   = ponS & ~prev_reg[4];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic       wrEn;
    logic       wrCtrl;
    logic       wrCause;
    logic       wrCmd;
    logic       mapped;
    logic [7:0] wd;
    assign mapped  = (paddr == WDRC_CTRL_ADDR) || (paddr == WDRC_CAUSE_ADDR)
                     || (paddr == WDRC_CMD_ADDR);
    assign wrEn    = psel & penable & pwrite & ~pready;
    assign wrCtrl  = wrEn & (paddr == WDRC_CTRL_ADDR);
    assign wrCause = wrEn & (paddr == WDRC_CAUSE_ADDR);
    assign wrCmd   = wrEn & (paddr == WDRC_CMD_ADDR);
    assign wd      = pwdata[7:0];

    logic restartCmd;
    logic vectorAck;
    assign restartCmd = wrCmd & wd[CMD_RESTART];
    assign vectorAck  = wrCmd & wd[CMD_VECTOR_ACK];

    // ------------------------------------------------------------------
    // control and status state
    // ------------------------------------------------------------------
    logic       irqFlag_reg;
    logic       irqEn_reg;
    logic       rstEn_reg;
    logic       chgEn_reg;
    logic [3:0] chgCnt_reg;
    logic [3:0] sel_reg;
    logic       wdogCause_reg;
    wdrc_cause_type cause_reg;
    logic       timeout;
    logic       irqEnEff;
    logic       rstEnEff;
    wdrc_mode_type mode;

    assign irqEnEff = alwaysOn ? 1'b0 : irqEn_reg;
    assign rstEnEff = alwaysOn | rstEn_reg | wdogCause_reg;
    assign mode = wdrc_mode_type'({rstEnEff, irqEnEff});

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chgEn_reg  <= 1'b0;
            chgCnt_reg <= 4'h0;
        end
        else if (wrCtrl && wd[CTRL_CHG_EN] && wd[CTRL_RST_EN])
        begin
            chgEn_reg  <= 1'b1;
            chgCnt_reg <= 4'(CHG_CYCLES);
        end
        else if (chgCnt_reg == 4'h1 || (wrCtrl && !wd[CTRL_CHG_EN]))
        begin
            chgEn_reg  <= 1'b0;
            chgCnt_reg <= 4'h0;
        end
        else if (chgCnt_reg != 4'h0)
        begin
            chgCnt_reg <= chgCnt_reg - 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstEn_reg <= 1'b0;
            sel_reg   <= SEL_RESET_VALUE;
        end
        else if (wrCtrl)
        begin
            if (wd[CTRL_RST_EN])
            begin
                rstEn_reg <= 1'b1;
            end
            else if (chgEn_reg && !wdogCause_reg)
            begin
                rstEn_reg <= 1'b0;
            end
            if (chgEn_reg)
            begin
                sel_reg <= {wd[CTRL_SEL3], wd[CTRL_SEL_HI:0]};
            end
        end
    end

    // vector ack drops enable in combined mode only; software may re-arm
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            irqEn_reg <= 1'b0;
        else if (wrCtrl)
            irqEn_reg <= wd[CTRL_IRQ_EN];
        else if (vectorAck && mode == WDRC_IRQ_RST)
            irqEn_reg <= 1'b0;
    end

    // irq flag, set wins over clear
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            irqFlag_reg <= 1'b0;
        else if (timeout && (mode == WDRC_IRQ_ONLY || mode == WDRC_IRQ_RST))
            irqFlag_reg <= 1'b1;
        else if ((wrCtrl && wd[CTRL_IRQ_FLAG]) || vectorAck)
            irqFlag_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------------
    logic [CNT_WIDTH-1:0] cnt_reg;
    logic [CNT_WIDTH-1:0] limit;
    logic                 selValid;
    assign selValid = (sel_reg <= SEL_MAX_CODE);
    assign limit    = (CNT_WIDTH'(1) << (BASE_TIMEOUT_LOG2 + int'(selValid ? sel_reg : 4'h0)))
                      - CNT_WIDTH'(1);
    assign timeout  = oscTick && (mode != WDRC_STOPPED) && (cnt_reg >= limit);

    // shortening period may expire at once
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= '0;
        end
        else if (restartCmd || timeout || mode == WDRC_STOPPED)
        begin
            cnt_reg <= '0;
        end
        else if (oscTick)
        begin
            cnt_reg <= cnt_reg + CNT_WIDTH'(1);
        end
    end

    // ------------------------------------------------------------------
    // time-out actions
    // ------------------------------------------------------------------
    logic rstPulse;
    // unserviced flag in combined mode resets
    assign rstPulse = timeout && (mode == WDRC_RST_ONLY
                      || (mode == WDRC_IRQ_RST && irqFlag_reg));

    // registered time-out outputs
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            systemReset <= 1'b0;
            timeoutIrq  <= 1'b0;
        end
        else
        begin
            systemReset <= rstPulse;
            timeoutIrq  <= irqFlag_reg & irqEnEff & globalIrqEnable;
        end
    end

    // ------------------------------------------------------------------
    // reset-cause flags (set wins over software clear; poweron clears the rest)
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wdogCause_reg <= 1'b0;
            cause_reg     <= '0;
        end
        else if (ponRise)
        begin
            wdogCause_reg     <= 1'b0;
            cause_reg.brownout <= 1'b0;
            cause_reg.pin     <= 1'b0;
            cause_reg.poweron <= 1'b1;
        end
        else
        begin
            wdogCause_reg <= rstPulse | (wdogCause_reg & ~(wrCause & ~wd[CAUSE_WDOG]));
            cause_reg.brownout <= brownRise
                                  | (cause_reg.brownout & ~(wrCause & ~wd[CAUSE_BROWNOUT]));
            cause_reg.pin <= pinRise | (cause_reg.pin & ~(wrCause & ~wd[CAUSE_PIN]));
            cause_reg.poweron <= cause_reg.poweron & ~(wrCause & ~wd[CAUSE_POWERON]);
        end
    end

    // ------------------------------------------------------------------
    // apb answer, one wait state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else if (psel && penable && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= '0;
            if (!pwrite && paddr == WDRC_CTRL_ADDR)
            begin
                prdata[7:0] <= {irqFlag_reg, irqEnEff, sel_reg[3], chgEn_reg,
                                rstEnEff, sel_reg[2:0]};
            end
            else if (!pwrite && paddr == WDRC_CAUSE_ADDR)
            begin
                prdata[7:0] <= {4'h0, wdogCause_reg, cause_reg.brownout,
                                cause_reg.pin, cause_reg.poweron};
            end
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

endmodule
